// ===== design/msp_device.sv
`timescale 1ns/1ps
`include "msp_defs.svh"
// Contract
// - Reference length 8, 16, 24 or 32
// - Reference bytes at addresses 01000..01011
// - MSB is bit 7 of first byte
// - Newest bit compared against reference LSB
// - Oldest window bit compared against reference MSB
// - Match output on bit clock, low disabled
// - Length code 00..11 means 8..32 bits
// - Match while mismatches within tolerance zero-three
// - Codes 000,001,100,111 are main states
// - Codes 010,011,110 are intermediate states
// - Host steps through intermediate states
// - Host changes mode pins only strobe low
// - Mode applied only on strobe rising edge
// - Strobe low phase at least 2 us
// - Receive bring-up 001,010,011 then 100
// - Boost when inhibit zero; data valid after
// - Transmit bring-up 001,110 then 111
// - Standby after reset; first strobe adopts pins
module msp_device #(
  parameter int REF_BITS = 32
) (
  input  wire logic      hclk,
  input  wire logic      hresetn,
  msp_if.device          link,
  input  wire logic      recovered_bit_clock,
  input  wire logic      demod_bit,
  output logic [2:0]     cur_mode,
  output logic           osc_on,
  output logic           baseband_on,
  output logic           synth_on,
  output logic           rx_front_on,
  output logic           tx_amp_on,
  output logic           wakeup_boost_inhibit,
  output logic           pattern_match
);
  if (REF_BITS != 32)
  begin : g_bad_width
    $error("REF_BITS must be 32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bytes, written through the serial side of the link
  logic [7:0]          ref_byte [4];
  logic [7:0]          corr_ctrl;
  logic [7:0]          rt_ctrl;
  wire  [REF_BITS-1:0] reference = {ref_byte[0], ref_byte[1], ref_byte[2], ref_byte[3]};
  wire                 correlator_on        = corr_ctrl[`MSP_CORR_ON_BIT];
  wire  [1:0]          reference_length_sel = corr_ctrl[`MSP_LEN_HI:`MSP_LEN_LO];
  wire  [1:0]          mismatch_allowance   = corr_ctrl[`MSP_TOL_HI:`MSP_TOL_LO];

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ref
      wire sel = link.cfg_we && (link.cfg_addr == `MSP_ADDR_REF0 + 5'(g));
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          ref_byte[g] <= 8'h00;
        else if (sel)
          ref_byte[g] <= link.cfg_wdata;
      end
    end
  endgenerate

  wire corr_sel = link.cfg_we && (link.cfg_addr == `MSP_ADDR_CORR);
  wire rt_sel   = link.cfg_we && (link.cfg_addr == `MSP_ADDR_RT);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      corr_ctrl <= 8'h00;
    else if (corr_sel)
      corr_ctrl <= link.cfg_wdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rt_ctrl <= 8'h00;
    else if (rt_sel)
      rt_ctrl <= link.cfg_wdata;
  end
  assign wakeup_boost_inhibit = rt_ctrl[`MSP_BOOST_INH_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Mode latch: pins sampled, applied on strobe rise only
  logic strobe_d;
  wire  strobe_rise = link.strobe && !strobe_d;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      strobe_d <= 1'b1;
      cur_mode <= msp_pkg::MSP_STANDBY;
    end
    else
    begin
      strobe_d <= link.strobe;
      if (strobe_rise)
        cur_mode <= link.mode_sel;
    end
  end

  // Block enables per decoded code
  always_comb
  begin
    osc_on      = 1'b1;
    baseband_on = 1'b0;
    synth_on    = 1'b0;
    rx_front_on = 1'b0;
    tx_amp_on   = 1'b0;
    case (msp_pkg::msp_mode_t'(cur_mode))
      msp_pkg::MSP_SLEEP:   osc_on = 1'b0;
      msp_pkg::MSP_STANDBY: ;
      msp_pkg::MSP_RX_BB:   baseband_on = 1'b1;
      msp_pkg::MSP_RX_SYN:
      begin
        baseband_on = 1'b1;
        synth_on    = 1'b1;
      end
      msp_pkg::MSP_RX:
      begin
        baseband_on = 1'b1;
        synth_on    = 1'b1;
        rx_front_on = 1'b1;
      end
      msp_pkg::MSP_TX_SYN:  synth_on = 1'b1;
      msp_pkg::MSP_TX:
      begin
        synth_on  = 1'b1;
        tx_amp_on = 1'b1;
      end
      default:              osc_on = 1'b1; // Undefined code 101 keeps oscillator only
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Correlator; the bit clock pin is sampled on hclk and its rise becomes
  // a one-cycle enable, so the config bytes never cross a clock domain
  logic                bit_clk_d;
  logic [REF_BITS-1:0] history;
  logic [REF_BITS-1:0] len_mask;
  logic [5:0]          err_run [REF_BITS+1];
  wire                 bit_en       = recovered_bit_clock && !bit_clk_d;
  wire  [REF_BITS-1:0] next_history = {history[REF_BITS-2:0], demod_bit};

  // Reference LSB sits at the last byte in use, so align it down
  wire  [REF_BITS-1:0] ref_aligned = reference >> (5'(3 - reference_length_sel) * 8);
  wire  [REF_BITS-1:0] diff = (next_history ^ ref_aligned) & len_mask;
  wire  [5:0]          errors      = err_run[REF_BITS];

  always_comb
  begin
    case (reference_length_sel)
      2'b00:   len_mask = 32'h0000_00ff;
      2'b01:   len_mask = 32'h0000_ffff;
      2'b10:   len_mask = 32'h00ff_ffff;
      default: len_mask = 32'hffff_ffff;
    endcase
  end

  // One adder per history position; masked positions add nothing
  assign err_run[0] = 6'h00;
  for (g = 0; g < REF_BITS; g++)
  begin : g_err
    assign err_run[g+1] = err_run[g] + 6'(diff[g]);
  end

  // Pin idles low, so the delayed copy resets low and no false rise follows
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bit_clk_d <= 1'b0;
    else
      bit_clk_d <= recovered_bit_clock;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      history <= '0;
    else if (bit_en)
      history <= next_history;
  end

  // Clearing does not wait for a bit edge, so disabling shows at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pattern_match <= 1'b0;
    else if (!correlator_on)
      pattern_match <= 1'b0;
    else if (bit_en)
      pattern_match <= (errors <= 6'(mismatch_allowance));
  end
endmodule : msp_device

// ===== design/msp_host.sv
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "msp_defs.svh"
module msp_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             rx_data_valid,
  msp_if.host              link
);
  typedef enum {H_IDLE, H_LOW, H_DWELL} msp_hstate_t;
  msp_hstate_t st;
  logic [31:0] dwell [3];
  logic [31:0] settle;
  logic [31:0] cnt;
  logic [2:0]  target;
  logic [2:0]  mode_q;
  logic [2:0]  plan_next;
  logic        busy_cmd;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        cfg_pend;
  logic        valid_cnt_on;

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  wire        ahb_go  = hsel && hready && htrans[1];
  wire        ahb_wr  = wr_pend;
  wire [31:0] stat    = {24'h0, rx_data_valid, st != H_IDLE, 3'h0, mode_q};
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata  <= 32'h0;
    end
    else
    begin
      wr_pend <= ahb_go && hwrite;
      wr_addr <= haddr[7:0];
      if (ahb_go && !hwrite)
        case (haddr[7:0])
          `MSP_H_STAT:   hrdata <= stat;
          `MSP_H_CMD:    hrdata <= {29'h0, target};
          `MSP_H_OSC:    hrdata <= dwell[0];
          `MSP_H_BB:     hrdata <= dwell[1];
          `MSP_H_SYN:    hrdata <= dwell[2];
          `MSP_H_SETTLE: hrdata <= settle;
          default:       hrdata <= 32'h0;
        endcase
    end
  end

  // Dwell registers hold cycle counts
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dwell[0] <= `MSP_DWELL_RST;
      dwell[1] <= `MSP_DWELL_RST;
      dwell[2] <= `MSP_DWELL_RST;
      settle   <= `MSP_DWELL_RST;
      target   <= msp_pkg::MSP_STANDBY;
      busy_cmd <= 1'b0;
      cfg_pend <= 1'b0;
      link.cfg_we    <= 1'b0;
      link.cfg_addr  <= 5'h00;
      link.cfg_wdata <= 8'h00;
    end
    else
    begin
      link.cfg_we <= 1'b0;
      busy_cmd    <= 1'b0;
      if (ahb_wr)
        case (wr_addr)
          `MSP_H_CMD:
          begin
            target   <= hwdata[2:0];
            busy_cmd <= 1'b1;
          end
          `MSP_H_CFG:
          begin
            link.cfg_we    <= 1'b1;
            link.cfg_addr  <= hwdata[12:8];
            link.cfg_wdata <= hwdata[7:0];
          end
          `MSP_H_OSC:    dwell[0] <= hwdata;
          `MSP_H_BB:     dwell[1] <= hwdata;
          `MSP_H_SYN:    dwell[2] <= hwdata;
          `MSP_H_SETTLE: settle   <= hwdata;
          default:       ;
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next step toward target through intermediate codes
  always_comb
  begin
    plan_next = target;
    if (target == msp_pkg::MSP_RX && mode_q == msp_pkg::MSP_STANDBY)
      plan_next = msp_pkg::MSP_RX_BB;
    else if (target == msp_pkg::MSP_RX && mode_q == msp_pkg::MSP_RX_BB)
      plan_next = msp_pkg::MSP_RX_SYN;
    else if (target == msp_pkg::MSP_TX && mode_q == msp_pkg::MSP_STANDBY)
      plan_next = msp_pkg::MSP_TX_SYN;
    // Any other start steps back through standby, the only safe entry point
    else if ((target == msp_pkg::MSP_RX &&
              !(mode_q inside {msp_pkg::MSP_RX_SYN, msp_pkg::MSP_RX})) ||
             (target == msp_pkg::MSP_TX &&
              !(mode_q inside {msp_pkg::MSP_TX_SYN, msp_pkg::MSP_TX})))
      plan_next = msp_pkg::MSP_STANDBY;
  end

  wire [31:0] dwell_now = (mode_q == msp_pkg::MSP_STANDBY) ? dwell[0] :
                          (mode_q == msp_pkg::MSP_RX_BB)   ? dwell[1] : dwell[2];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st            <= H_IDLE;
      cnt           <= 32'h0;
      mode_q        <= msp_pkg::MSP_STANDBY;
      link.strobe   <= 1'b1;
      link.mode_sel <= msp_pkg::MSP_STANDBY;
      rx_data_valid <= 1'b0;
      valid_cnt_on  <= 1'b0;
    end
    else
    begin
      case (st)
        H_IDLE:
          if (busy_cmd || mode_q != target)
          begin
            link.strobe   <= 1'b0;
            link.mode_sel <= plan_next;
            cnt           <= 32'h0;
            st            <= H_LOW;
          end
        H_LOW:
        begin
          cnt <= cnt + 32'h1;
          if (cnt >= `MSP_STROBE_LOW_CY)
          begin
            link.strobe <= 1'b1;
            mode_q      <= link.mode_sel;
            cnt         <= 32'h0;
            st          <= (link.mode_sel == target) ? H_IDLE : H_DWELL;
            rx_data_valid <= 1'b0;
            valid_cnt_on  <= link.mode_sel == msp_pkg::MSP_RX ||
                             link.mode_sel == msp_pkg::MSP_TX;
          end
        end
        H_DWELL:
        begin
          cnt <= cnt + 32'h1;
          if (cnt >= dwell_now)
            st <= H_IDLE;
        end
        default: st <= H_IDLE;
      endcase
      if (st != H_LOW && valid_cnt_on)
      begin
        if (settle == 32'h0 || cnt >= settle)
        begin
          rx_data_valid <= 1'b1;
          valid_cnt_on  <= 1'b0;
        end
        else if (st == H_IDLE)
          cnt <= cnt + 32'h1;
      end
    end
  end
endmodule : msp_host

// ===== pkg/msp_defs.svh
`ifndef MSP_DEFS_SVH
`define MSP_DEFS_SVH

// Device byte addresses (5-bit)
`define MSP_ADDR_REF0     5'h08
`define MSP_ADDR_REF1     5'h09
`define MSP_ADDR_REF2     5'h0a
`define MSP_ADDR_REF3     5'h0b
`define MSP_ADDR_CORR     5'h06
`define MSP_ADDR_RT       5'h01

// Correlator control byte fields and the boost inhibit bit of the RT byte
`define MSP_CORR_ON_BIT   7
`define MSP_LEN_HI        6
`define MSP_LEN_LO        5
`define MSP_TOL_HI        4
`define MSP_TOL_LO        3
`define MSP_BOOST_INH_BIT 0

// Host controller AHB offsets
`define MSP_H_CMD         8'h00
`define MSP_H_STAT        8'h04
`define MSP_H_CFG         8'h08
`define MSP_H_OSC         8'h0c
`define MSP_H_BB          8'h10
`define MSP_H_SYN         8'h14
`define MSP_H_SETTLE      8'h18

// Minimum strobe low time and dwell defaults
`define MSP_STROBE_LOW_NS 2000
`define MSP_CLK_NS        40
`define MSP_STROBE_LOW_CY ((`MSP_STROBE_LOW_NS + `MSP_CLK_NS - 1) / `MSP_CLK_NS)
`define MSP_DWELL_RST     32'h0000_0100

`endif

// ===== pkg/msp_if.sv
`timescale 1ns/1ps
interface msp_if;
  logic [2:0] mode_sel;
  logic       strobe;
  logic       cfg_we;
  logic [4:0] cfg_addr;
  logic [7:0] cfg_wdata;
  modport device (input mode_sel, input strobe, input cfg_we, input cfg_addr, input cfg_wdata);
  modport host   (output mode_sel, output strobe, output cfg_we, output cfg_addr,
                  output cfg_wdata);
endinterface : msp_if

// ===== pkg/msp_pkg.sv
package msp_pkg;
  typedef enum logic [2:0] {
    MSP_SLEEP   = 3'h0,
    MSP_STANDBY = 3'h1,
    MSP_RX_BB   = 3'h2,
    MSP_RX_SYN  = 3'h3,
    MSP_RX      = 3'h4,
    MSP_TX_SYN  = 3'h6,
    MSP_TX      = 3'h7
  } msp_mode_t;
endpackage : msp_pkg

// ===== testbench/mode_sequencer_pattern_match_tb.sv
`timescale 1ns/1ps
`include "msp_defs.svh"
module mode_sequencer_pattern_match_tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_data_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cur_mode;
  logic        recovered_bit_clock, demod_bit, osc_on, baseband_on, synth_on;
  logic        rx_front_on, tx_amp_on, wakeup_boost_inhibit, pattern_match;
  int          fail_count, check_count;
  localparam logic [31:0] REF = 32'h93aa5c31;
  msp_if link_if ();
  msp_host u_msp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_data_valid(rx_data_valid),
    .link(link_if));
  msp_device u_msp_device (.hclk(hclk), .hresetn(hresetn), .link(link_if),
    .recovered_bit_clock(recovered_bit_clock), .demod_bit(demod_bit), .cur_mode(cur_mode),
    .osc_on(osc_on), .baseband_on(baseband_on), .synth_on(synth_on),
    .rx_front_on(rx_front_on), .tx_amp_on(tx_amp_on),
    .wakeup_boost_inhibit(wakeup_boost_inhibit), .pattern_match(pattern_match));
  msp_asserts u_msp_asserts (.hclk(hclk), .hresetn(hresetn), .mode_sel(link_if.mode_sel),
    .strobe(link_if.strobe), .cfg_we(link_if.cfg_we), .cfg_addr(link_if.cfg_addr),
    .cfg_wdata(link_if.cfg_wdata), .cur_mode(cur_mode), .osc_on(osc_on),
    .baseband_on(baseband_on), .synth_on(synth_on), .rx_front_on(rx_front_on),
    .tx_amp_on(tx_amp_on), .recovered_bit_clock(recovered_bit_clock),
    .pattern_match(pattern_match));
  ////////////////////////////////////////
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task cfg(input logic [4:0] a, input logic [7:0] d);
    ahb(1'b1, `MSP_H_CFG, {19'h0, a, d});
  endtask : cfg
  task units(input logic [4:0] e);
    chk({27'h0, osc_on, baseband_on, synth_on, rx_front_on, tx_amp_on}, {27'h0, e}, "units");
  endtask : units
  // Polls status up to 300 times, then checks the last read
  task go(input logic [2:0] m, input logic [7:0] e);
    ahb(1'b1, `MSP_H_CMD, {29'h0, m});
    for (int i = 0; i < 300; i++)
    begin
      ahb(1'b0, `MSP_H_STAT, 32'h0);
      if (rd[7:0] === e)
        break;
    end
    chk(rd, {24'h0, e}, "status");
  endtask : go
  task shift(input logic b);
    @(posedge hclk);
    demod_bit <= b;
    @(posedge hclk);
    recovered_bit_clock <= 1'b1;
    @(posedge hclk);
    recovered_bit_clock <= 1'b0;
    @(posedge hclk);
  endtask : shift
  ////////////////////////////////////////
  task t_reset;
    ahb(1'b0, `MSP_H_STAT, 32'h0);
    chk(rd, 32'h1, "status after reset");
    chk({29'h0, cur_mode}, 32'h1, "mode after reset");
    ahb(1'b0, `MSP_H_OSC, 32'h0);
    chk(rd, `MSP_DWELL_RST, "dwell reset");
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  task t_modes;
    for (int i = 0; i < 4; i++)
      ahb(1'b1, `MSP_H_OSC + 8'(4 * i), 32'h4);
    cfg(`MSP_ADDR_RT, 8'h01);
    repeat (2) @(posedge hclk);
    chk({31'h0, wakeup_boost_inhibit}, 32'h1, "boost inhibit set");
    cfg(`MSP_ADDR_RT, 8'h00);
    repeat (2) @(posedge hclk);
    chk({31'h0, wakeup_boost_inhibit}, 32'h0, "boost inhibit");
    go(3'h4, 8'h84);
    units(5'h1e);
    chk({31'h0, rx_data_valid}, 32'h1, "receive valid");
    go(3'h1, 8'h01);
    units(5'h10);
    go(3'h7, 8'h87);
    units(5'h15);
    go(3'h0, 8'h00);
    units(5'h00);
    go(3'h4, 8'h84);
    go(3'h5, 8'h05);
    units(5'h10);
    go(3'h1, 8'h01);
    $display("test modes done");
  endtask : t_modes
  task t_corr;
    int          n;
    logic [31:0] stm;
    for (int b = 0; b < 4; b++)
      cfg(`MSP_ADDR_REF0 + 5'(b), REF[31 - 8 * b -: 8]);
    for (int l = 0; l < 4; l++)
      for (int f = 0; f < 2; f++)
      begin
        n = 8 * (l + 1);
        cfg(`MSP_ADDR_CORR, {1'b1, 2'(l), 2'(l), 3'h0});
        // Older bits carry the inverse so a wide compare would miss
        stm = (~REF << n) | (REF >> (32 - n));
        if (l + f > 0) stm[0] = ~stm[0];
        if (l + f > 1) stm[n - 1] = ~stm[n - 1];
        if (l + f > 2) stm[1] = ~stm[1];
        if (l + f > 3) stm[2] = ~stm[2];
        for (int i = 31; i >= 0; i--)
          shift(stm[i]);
        chk({31'h0, pattern_match}, {31'h0, f == 0}, "match");
      end
    cfg(`MSP_ADDR_CORR, 8'h00);
    shift(1'b1);
    chk({31'h0, pattern_match}, 32'h0, "match when off");
    $display("test correlator done");
  endtask : t_corr
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////
  initial
  begin
    {hresetn, hwrite, recovered_bit_clock, demod_bit} = 4'h0;
    hsel = 1'b1;
    hsize = 3'h2;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_modes();
    t_corr();
    wrap_up();
  end
  // Tests need about 1900 cycles; allow ample margin
  initial
  begin
    repeat (60000) @(posedge hclk);
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : mode_sequencer_pattern_match_tb

// ===== testbench/msp_asserts.sv
`timescale 1ns/1ps
`include "msp_defs.svh"
module msp_asserts (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic [2:0] mode_sel,
  input wire logic       strobe,
  input wire logic       cfg_we,
  input wire logic [4:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [2:0] cur_mode,
  input wire logic       osc_on,
  input wire logic       baseband_on,
  input wire logic       synth_on,
  input wire logic       rx_front_on,
  input wire logic       tx_amp_on,
  input wire logic       recovered_bit_clock,
  input wire logic       pattern_match
);
  localparam int LOW_MIN = `MSP_STROBE_LOW_NS / `MSP_CLK_NS;
  logic [7:0] low_cnt;
  logic       corr_on;
  ////////////////////////////////////////
  // Saturates so a long low phase never wraps
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) low_cnt <= 8'h00;
    else if (strobe) low_cnt <= 8'h00;
    else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) corr_on <= 1'b0;
    else if (cfg_we && cfg_addr == `MSP_ADDR_CORR) corr_on <= cfg_wdata[`MSP_CORR_ON_BIT];
  ////////////////////////////////////////
  property p_mode_steady;
    @(posedge hclk) disable iff (!hresetn) !$stable(mode_sel) |-> !strobe;
  endproperty
  a_mode_steady: assert property (p_mode_steady)
    else $error("mode pins moved with strobe high");
  property p_low_width;
    @(posedge hclk) disable iff (!hresetn) $rose(strobe) |-> low_cnt >= LOW_MIN;
  endproperty
  a_low_width: assert property (p_low_width)
    else $error("strobe low phase too short");
  property p_apply;
    @(posedge hclk) disable iff (!hresetn) $rose(strobe) |-> ##[1:2] cur_mode == mode_sel;
  endproperty
  a_apply: assert property (p_apply)
    else $error("mode not applied after strobe rise");
  property p_mode_cause;
    @(posedge hclk) disable iff (!hresetn)
      !$stable(cur_mode) |-> strobe && cur_mode == mode_sel;
  endproperty
  a_mode_cause: assert property (p_mode_cause)
    else $error("mode changed without strobe rise");
  property p_rx_order;
    @(posedge hclk) disable iff (!hresetn) !$stable(mode_sel) |->
      (mode_sel != 3'h4 || $past(mode_sel) == 3'h3) &&
      (mode_sel != 3'h3 || $past(mode_sel) == 3'h2);
  endproperty
  a_rx_order: assert property (p_rx_order)
    else $error("receive bring-up out of order");
  property p_tx_order;
    @(posedge hclk) disable iff (!hresetn) !$stable(mode_sel) |->
      (mode_sel != 3'h7 || $past(mode_sel) == 3'h6) &&
      (mode_sel != 3'h6 || $past(mode_sel) == 3'h1);
  endproperty
  a_tx_order: assert property (p_tx_order)
    else $error("transmit bring-up out of order");
  property p_rx_decode;
    @(posedge hclk) disable iff (!hresetn)
      baseband_on == (cur_mode inside {3'h2, 3'h3, 3'h4}) && rx_front_on == (cur_mode == 3'h4);
  endproperty
  a_rx_decode: assert property (p_rx_decode)
    else $error("receive units decoded wrongly");
  property p_tx_decode;
    @(posedge hclk) disable iff (!hresetn) osc_on == (cur_mode != 3'h0) &&
      synth_on == (cur_mode inside {3'h3, 3'h4, 3'h6, 3'h7}) && tx_amp_on == (cur_mode == 3'h7);
  endproperty
  a_tx_decode: assert property (p_tx_decode)
    else $error("transmit units decoded wrongly");
  property p_match_off;
    @(posedge hclk) disable iff (!hresetn) !corr_on |=> !pattern_match;
  endproperty
  a_match_off: assert property (p_match_off)
    else $error("match high while correlator off");
  property p_match_edge;
    @(posedge hclk) disable iff (!hresetn)
      $rose(pattern_match) |-> $past(recovered_bit_clock) && !$past(recovered_bit_clock, 2);
  endproperty
  a_match_edge: assert property (p_match_edge)
    else $error("match rose without a bit clock rise");
endmodule : msp_asserts
